// ---- rtl/irq_mask_flag_unit_defines.vh ----
// Purpose: constants for the interrupt mask and flag unit
// Assumes: APB byte addresses, 32-bit words, 8-bit registers in low bits
// Notes: offsets are register indices; byte address is four times the index
`ifndef IRQ_MASK_FLAG_UNIT_DEFINES_VH
`define IRQ_MASK_FLAG_UNIT_DEFINES_VH

// register indices
`define IDX_TIMER_FLAGS 6'h38
`define IDX_TIMER_MASK 6'h39
`define IDX_PIN_MASK 6'h3b
`define IDX_PIN_FLAGS 6'h3a
`define IDX_SENSE_CTRL 6'h35
`define IDX_EDGE_CTRL 6'h36
`define IDX_GLOBAL_CTRL 6'h3f

// reset values
`define RST_REG8 8'h00

// pin bit positions in pin mask and pin flag registers
`define BIT_PIN1 7
`define BIT_PIN0 6
`define BIT_PIN2 5
`define PIN_RSVD_MASK 8'he0

// sense, edge and global control field positions
`define BIT_P1_SENSE_HI 3
`define BIT_P1_SENSE_LO 2
`define BIT_P0_SENSE_HI 1
`define BIT_P0_SENSE_LO 0
`define BIT_P2_EDGE 0
`define BIT_GIE 7

// sense encodings
`define SENSE_LOW 2'b00
`define SENSE_ANY 2'b01
`define SENSE_FALL 2'b10
`define SENSE_RISE 2'b11

// timer flag positions
`define BIT_T1_OVF 7
`define BIT_T1_CMPA 6
`define BIT_T1_CMPB 5
`define BIT_T2_OVF 4
`define BIT_T1_CAP 3
`define BIT_T2_CMP 2
`define BIT_T0_OVF 1
`define BIT_T0_CMP 0

// vector addresses
`define VEC_PIN0 6'h02
`define VEC_PIN1 6'h04
`define VEC_PIN2 6'h06
`define VEC_T2_CMP 6'h08
`define VEC_T2_OVF 6'h0a
`define VEC_T1_CAP 6'h0c
`define VEC_T1_CMPA 6'h0e
`define VEC_T1_CMPB 6'h10
`define VEC_T1_OVF 6'h12
`define VEC_T0_CMP 6'h14
`define VEC_T0_OVF 6'h16

`endif

// ---- rtl/irq_mask_flag_unit.v ----
// Purpose: interrupt mask, flag and dispatch logic with an APB slave
// Assumes: pins are asynchronous; timer events are one-cycle pulses
// Notes: one request to the core at a time, lowest vector first
`timescale 1ns/10ps
`include "irq_mask_flag_unit_defines.vh"

module irq_mask_flag_unit
(
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // external interrupt pins
  input wire pinRequest0,
  input wire pinRequest1,
  input wire pinRequest2,
  // timer events, one-cycle pulses, and the timer 1 pwm mode level
  input wire t1OverflowEvt,
  input wire t1PwmBottomEvt,
  input wire t1PwmMode,
  input wire t1CmpaMatch,
  input wire t1CmpbMatch,
  input wire t2OverflowEvt,
  input wire t1CaptureEvt,
  input wire t2CmpMatch,
  input wire t0OverflowEvt,
  input wire t0CmpMatch,
  // core dispatch
  input wire irqAck,
  input wire retiDone,
  output reg irqReq,
  output reg [5:0] irqVector,
  output reg globalEnable
);

  // state
  reg [7:0] pinMask_q;
  reg [2:0] pinFlags_q;
  reg [7:0] timerMask_q;
  reg [7:0] timerFlags_q;
  reg [3:0] senseCtrl_q;
  reg pin2Edge_q;
  reg gie_q;
  wire [2:0] pinNow;
  wire [2:0] pinPrev;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] srcSel_q;

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // decoded apb access
  wire [5:0] regIdx = paddr[7:2];
  wire addrHi = |paddr[11:8];
  wire apbWrite = psel & penable & pwrite & pready;
  wire apbRead = psel & penable & ~pwrite;

  function isReg;
    input [5:0] idx;
    input [5:0] target;
    input hi;
    begin
      isReg = (idx == target) & ~hi;
    end
  endfunction

  function known;
    input [5:0] idx;
    input hi;
    begin
      known = ~hi & ((idx == `IDX_TIMER_FLAGS) | (idx == `IDX_TIMER_MASK) |
        (idx == `IDX_PIN_MASK) | (idx == `IDX_PIN_FLAGS) |
        (idx == `IDX_SENSE_CTRL) | (idx == `IDX_EDGE_CTRL) |
        (idx == `IDX_GLOBAL_CTRL));
    end
  endfunction

  // pin synchronisers, three stages each; all start high so reset makes no false edge
  wire [2:0] pinIn = {pinRequest2, pinRequest1, pinRequest0};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : pinSync
      reg stageA_q;
      reg stageB_q;
      reg stageC_q;
      reg level_q;
      wire levelNow = (stageB_q & stageC_q) | (level_q & (stageB_q | stageC_q));
      always @(posedge ref_clk)
      begin
        if (!rst_b)
        begin
          stageA_q <= 1'b1;
          stageB_q <= 1'b1;
          stageC_q <= 1'b1;
          level_q <= 1'b1;
        end
        else
        begin
          // pins read regardless of direction
          stageA_q <= pinIn[g];
          stageB_q <= stageA_q;
          stageC_q <= stageB_q;
          level_q <= levelNow;
        end
      end
      assign pinNow[g] = levelNow;
      assign pinPrev[g] = level_q;
    end
  endgenerate

  // edges of the settled level
  wire [2:0] rise = pinNow & ~pinPrev;
  wire [2:0] fall = ~pinNow & pinPrev;

  function senseHit;
    input [1:0] mode;
    input now;
    input r;
    input f;
    begin
      case (mode)
        `SENSE_LOW: senseHit = ~now;
        `SENSE_ANY: senseHit = r | f;
        `SENSE_FALL: senseHit = f;
        default: senseHit = r;
      endcase
    end
  endfunction

  // events per pin
  wire p0Evt = senseHit(senseCtrl_q[1:0], pinNow[0], rise[0], fall[0]);
  wire p1Evt = senseHit(senseCtrl_q[3:2], pinNow[1], rise[1], fall[1]);
  wire p2Evt = pin2Edge_q ? rise[2] : fall[2];
  wire p0Level = senseCtrl_q[1:0] == `SENSE_LOW;
  wire p1Level = senseCtrl_q[3:2] == `SENSE_LOW;

  // timer events in flag order 7..0
  wire t1Ovf = t1PwmMode ? t1PwmBottomEvt : t1OverflowEvt;
  wire [7:0] timerEvt = {t1Ovf, t1CmpaMatch, t1CmpbMatch, t2OverflowEvt,
    t1CaptureEvt, t2CmpMatch, t0OverflowEvt, t0CmpMatch};

  // pending sources by priority, lowest vector first
  // 0 pin0,1 pin1,2 pin2,3 t2cmp,4 t2ovf,5 cap,6 cmpa,7 cmpb,8 t1ovf,9 t0cmp,10 t0ovf
  wire [10:0] pend;
  assign pend[0] = pinFlags_q[0] & pinMask_q[`BIT_PIN0];
  assign pend[1] = pinFlags_q[1] & pinMask_q[`BIT_PIN1];
  assign pend[2] = pinFlags_q[2] & pinMask_q[`BIT_PIN2];
  assign pend[3] = timerFlags_q[`BIT_T2_CMP] & timerMask_q[`BIT_T2_CMP];
  assign pend[4] = timerFlags_q[`BIT_T2_OVF] & timerMask_q[`BIT_T2_OVF];
  assign pend[5] = timerFlags_q[`BIT_T1_CAP] & timerMask_q[`BIT_T1_CAP];
  assign pend[6] = timerFlags_q[`BIT_T1_CMPA] & timerMask_q[`BIT_T1_CMPA];
  assign pend[7] = timerFlags_q[`BIT_T1_CMPB] & timerMask_q[`BIT_T1_CMPB];
  assign pend[8] = timerFlags_q[`BIT_T1_OVF] & timerMask_q[`BIT_T1_OVF];
  assign pend[9] = timerFlags_q[`BIT_T0_CMP] & timerMask_q[`BIT_T0_CMP];
  assign pend[10] = timerFlags_q[`BIT_T0_OVF] & timerMask_q[`BIT_T0_OVF];

  function [5:0] vecOf;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: vecOf = `VEC_PIN0;
        4'h1: vecOf = `VEC_PIN1;
        4'h2: vecOf = `VEC_PIN2;
        4'h3: vecOf = `VEC_T2_CMP;
        4'h4: vecOf = `VEC_T2_OVF;
        4'h5: vecOf = `VEC_T1_CAP;
        4'h6: vecOf = `VEC_T1_CMPA;
        4'h7: vecOf = `VEC_T1_CMPB;
        4'h8: vecOf = `VEC_T1_OVF;
        4'h9: vecOf = `VEC_T0_CMP;
        default: vecOf = `VEC_T0_OVF;
      endcase
    end
  endfunction

  // lowest index wins
  reg [3:0] winSel;
  integer k;
  always @*
  begin
    winSel = 4'h0;
    for (k = 10; k >= 0; k = k - 1)
      if (pend[k])
        winSel = k[3:0];
  end
  wire anyPend = |pend;

  // dispatch state machine
  wire takeAck = (state_q == ST_WAIT) & irqAck;
  always @*
  begin
    case (state_q)
      ST_IDLE: state_d = (anyPend & gie_q) ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_d = irqAck ? ST_IDLE : ST_WAIT;
      default: state_d = ST_IDLE;
    endcase
  end

  // hardware clear on entry, one-hot over sources
  wire [10:0] hwClr = takeAck ? (11'h001 << srcSel_q) : 11'h000;

  // write-one clears
  wire pinFlagWr = apbWrite & isReg(regIdx, `IDX_PIN_FLAGS, addrHi);
  wire timFlagWr = apbWrite & isReg(regIdx, `IDX_TIMER_FLAGS, addrHi);
  wire [2:0] pinW1c = pinFlagWr ?
    {pwdata[`BIT_PIN2], pwdata[`BIT_PIN1], pwdata[`BIT_PIN0]} : 3'h0;
  wire [7:0] timW1c = timFlagWr ? pwdata[7:0] : 8'h00;
  wire [7:0] timHwClr = {hwClr[8], hwClr[6], hwClr[7], hwClr[4],
    hwClr[5], hwClr[3], hwClr[10], hwClr[9]};

  // pin flags: level mode follows the pin and holds no memory; set wins over clear
  wire [2:0] pinSet = {p2Evt, p1Evt, p0Evt};
  wire [2:0] pinKeep = pinFlags_q & ~pinW1c & ~hwClr[2:0];
  wire [2:0] pinNext = {pinSet[2] | pinKeep[2],
    p1Level ? p1Evt : (pinSet[1] | pinKeep[1]),
    p0Level ? p0Evt : (pinSet[0] | pinKeep[0])};

  // register write strobes
  wire pinMaskWr = apbWrite & isReg(regIdx, `IDX_PIN_MASK, addrHi);
  wire timMaskWr = apbWrite & isReg(regIdx, `IDX_TIMER_MASK, addrHi);
  wire senseWr = apbWrite & isReg(regIdx, `IDX_SENSE_CTRL, addrHi);
  wire edgeWr = apbWrite & isReg(regIdx, `IDX_EDGE_CTRL, addrHi);
  wire gieWr = apbWrite & isReg(regIdx, `IDX_GLOBAL_CTRL, addrHi);

  // pending flags
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pinFlags_q <= 3'h0;
      timerFlags_q <= `RST_REG8;
    end
    else
    begin
      pinFlags_q <= pinNext;
      timerFlags_q <= timerEvt | (timerFlags_q & ~timW1c & ~timHwClr);
    end
  end

  // dispatch state and latched source
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      srcSel_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d == ST_WAIT)
        srcSel_q <= winSel;
    end
  end

  // software configuration
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pinMask_q <= `RST_REG8;
      timerMask_q <= `RST_REG8;
      senseCtrl_q <= 4'h0;
      pin2Edge_q <= 1'b0;
    end
    else
    begin
      if (pinMaskWr)
        pinMask_q <= pwdata[7:0] & `PIN_RSVD_MASK;
      if (timMaskWr)
        timerMask_q <= pwdata[7:0];
      if (senseWr)
        senseCtrl_q <= pwdata[3:0];
      if (edgeWr)
        pin2Edge_q <= pwdata[`BIT_P2_EDGE];
    end
  end

  // global enable: taking an interrupt beats software and return
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      gie_q <= 1'b0;
    else if (takeAck)
      gie_q <= 1'b0;
    else if (gieWr)
      gie_q <= pwdata[`BIT_GIE];
    else if (retiDone)
      gie_q <= 1'b1;
  end

  // registered view for the core
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      irqReq <= 1'b0;
      irqVector <= 6'h00;
      globalEnable <= 1'b0;
    end
    else
    begin
      irqReq <= (state_d == ST_WAIT);
      irqVector <= (state_q == ST_IDLE) ? vecOf(winSel) : vecOf(srcSel_q);
      globalEnable <= takeAck ? 1'b0 : gie_q;
    end
  end

  // apb answer: one wait state, reads registered
  reg [7:0] rdMux;
  always @*
  begin
    rdMux = 8'h00;
    if (~addrHi)
      case (regIdx)
        `IDX_TIMER_FLAGS: rdMux = timerFlags_q;
        `IDX_TIMER_MASK: rdMux = timerMask_q;
        `IDX_PIN_MASK: rdMux = pinMask_q;
        `IDX_PIN_FLAGS: rdMux = {pinFlags_q[1], pinFlags_q[0], pinFlags_q[2], 5'h00};
        `IDX_SENSE_CTRL: rdMux = {4'h0, senseCtrl_q};
        `IDX_EDGE_CTRL: rdMux = {7'h00, pin2Edge_q};
        `IDX_GLOBAL_CTRL: rdMux = {gie_q, 7'h00};
        default: rdMux = 8'h00;
      endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known(regIdx, addrHi);
      prdata <= (apbRead & ~pready) ? {24'h000000, rdMux} : 32'h00000000;
    end
  end

endmodule

// ---- verification/irq_mask_flag_unit_checker.sv ----
// Purpose: port assertions for the interrupt mask and flag unit
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the unit
`timescale 1ns/10ps
module irq_mask_flag_unit_checker (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  // dispatch
  input wire irqAck,
  input wire retiDone,
  input wire irqReq,
  input wire [5:0] irqVector,
  input wire globalEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence sTaken;
    irqReq && irqAck;
  endsequence
  sequence sWaiting;
    irqReq && !irqAck;
  endsequence
  sequence sRead;
    pready && !pwrite;
  endsequence
  reqGated_a: assert property ($rose(irqReq) |-> globalEnable)
    else $error("request without global enable");
  ackClears_a: assert property (sTaken |=> !irqReq && !globalEnable)
    else $error("ack did not drop request");
  vecHeld_a: assert property (sWaiting |=> irqReq && $stable(irqVector))
    else $error("request or vector moved");
  vecLegal_a: assert property (irqReq |-> irqVector inside {[2:22]} && !irqVector[0])
    else $error("vector out of table");
  retiSets_a: assert property (retiDone && !irqAck && !irqReq && !(pready && pwrite)
    |-> ##2 globalEnable)
    else $error("return did not enable");
  readyPulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready not a single pulse");
  readyWait_a: assert property (psel && penable |-> ##[0:2] pready)
    else $error("no ready");
  rsvdZero_a: assert property (sRead |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  pinRsvd_a: assert property (sRead and (paddr[7:3] == 5'h1d) |-> prdata[4:0] == 5'h0)
    else $error("pin reserved bits set");
endmodule

bind irq_mask_flag_unit irq_mask_flag_unit_checker u_chk (.ref_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .irqAck, .retiDone, .irqReq, .irqVector, .globalEnable);

// ---- verification/core_model.sv ----
// Purpose: processor core side of interrupt dispatch
// Assumes: ack after lat cycles of request
// Notes: optional return pulse re-enables interrupts
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // dispatch
  input wire irqReq,
  input wire [5:0] irqVector,
  input wire [3:0] lat,
  input wire autoReti,
  output logic irqAck,
  output logic retiDone,
  output logic taken,
  output logic [5:0] takenVec
);
  logic [3:0] waitCnt;
  logic [3:0] retiCnt;
  always @(posedge ref_clk)
  begin
    irqAck <= 1'b0;
    retiDone <= 1'b0;
    taken <= 1'b0;
    if (!rst_b)
    begin
      waitCnt <= 4'h0;
      retiCnt <= 4'h0;
    end
    else if (irqReq && !irqAck && waitCnt >= lat)
    begin
      irqAck <= 1'b1;
      taken <= 1'b1;
      takenVec <= irqVector;
      waitCnt <= 4'h0;
      retiCnt <= autoReti ? 4'h6 : 4'h0;
    end
    else
    begin
      waitCnt <= (irqReq && !irqAck) ? waitCnt + 4'h1 : 4'h0;
      retiDone <= (retiCnt == 4'h1);
      retiCnt <= (retiCnt != 4'h0) ? retiCnt - 4'h1 : 4'h0;
    end
  end
endmodule

// ---- verification/tb_irq_mask_flag_unit.sv ----
// Purpose: self-checking bench for the interrupt mask and flag unit
// Assumes: apb master and core model drive the unit
// Notes: flags, masks, senses, priority and w1c
`timescale 1ns/10ps
module tb_irq_mask_flag_unit;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic psel = 0, penable = 0, pwrite = 0, e, pwm = 0, bot = 0, autoReti = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, seed = 32'h0cba;
  logic pready, pslverr, irqAck, retiDone, irqReq, globalEnable, taken;
  logic [2:0] pin = 3'h7;
  logic [7:0] evt = 0;
  logic [3:0] lat = 0;
  logic [5:0] irqVector, takenVec;
  logic [5:0] vt [8] = '{6'h14, 6'h16, 6'h08, 6'h0c, 6'h0a, 6'h10, 6'h0e, 6'h12};
  logic [5:0] expQ [$];
  int n_fail = 0, checked = 0, cyc = 0;
  irq_mask_flag_unit u_irq_mask_flag_unit (.ref_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pinRequest0(pin[0]), .pinRequest1(pin[1]),
    .pinRequest2(pin[2]), .t1OverflowEvt(evt[7]), .t1PwmBottomEvt(bot), .t1PwmMode(pwm),
    .t1CmpaMatch(evt[6]), .t1CmpbMatch(evt[5]), .t2OverflowEvt(evt[4]), .t1CaptureEvt(evt[3]),
    .t2CmpMatch(evt[2]), .t0OverflowEvt(evt[1]), .t0CmpMatch(evt[0]), .irqAck, .retiDone,
    .irqReq, .irqVector, .globalEnable);
  core_model u_core_model (.ref_clk, .rst_b, .irqReq, .irqVector, .lat, .autoReti, .irqAck,
    .retiDone, .taken, .takenVec);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 8'h0);
    chk("register", x, r);
  endtask
  task pulse(input logic [7:0] x, input logic b);
    @(posedge ref_clk);
    evt <= x;
    bot <= b;
    @(posedge ref_clk);
    evt <= 0;
    bot <= 0;
  endtask
  task waitVec(input logic [5:0] v);
    do @(posedge ref_clk); while (taken !== 1'b1);
    chk("vector", {26'h0, v}, {26'h0, takenVec});
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    for (int i = 0; i < 4; i++)
      rd(12'(12'he0 + 4 * i), 32'h0);
    apb(0, 12'h100, 8'h0);
    chk("slverr", 32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      apb(1, 12'he4, seed[7:0]);
      rd(12'he4, {24'h0, seed[7:0]});
    end
    apb(1, 12'hec, 8'hff);
    rd(12'hec, 32'he0);
    apb(1, 12'hec, 8'h0);
    apb(1, 12'he4, 8'hff);
    for (int i = 0; i < 8; i++)
    begin
      lat <= i[3:0];
      pulse(8'h1 << i, 0);
      rd(12'he0, 32'h1 << i);
      apb(1, 12'hfc, 8'h80);
      waitVec(vt[i]);
      rd(12'he0, 32'h0);
      chk("gie", 32'h0, {31'h0, globalEnable});
    end
    pwm <= 1;
    pulse(8'h80, 0);
    rd(12'he0, 32'h0);
    pulse(8'h0, 1);
    rd(12'he0, 32'h80);
    pwm <= 0;
    apb(1, 12'he4, 8'h0);
    pulse(8'hff, 0);
    apb(1, 12'he0, 8'h0);
    rd(12'he0, 32'hff);
    apb(1, 12'he0, 8'h0f);
    rd(12'he0, 32'hf0);
    apb(1, 12'hfc, 8'h80);
    repeat (20) @(posedge ref_clk) #1;
    chk("request", 32'h0, {31'h0, irqReq});
    apb(1, 12'hfc, 8'h0);
    apb(1, 12'he0, 8'hff);
    pulse(8'hff, 0);
    apb(1, 12'he4, 8'hff);
    autoReti <= 1;
    lat <= 4;
    apb(1, 12'hfc, 8'h80);
    for (int v = 8; v < 24; v += 2)
      for (int i = 0; i < 8; i++)
        if (vt[i] == v)
          expQ.push_back(vt[i]);
    while (expQ.size() > 0)
      waitVec(expQ.pop_front());
    apb(1, 12'he4, 8'h0);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, 12'hd4, {4'h0, m[1:0], m[1:0]});
      apb(1, 12'hd8, {7'h0, m[0]});
      apb(1, 12'he8, 8'he0);
      pin <= 0;
      repeat (8) @(posedge ref_clk);
      rd(12'he8, {24'h0, m != 3, m != 3, !m[0], 5'h0});
      pin <= 7;
      repeat (8) @(posedge ref_clk);
    end
    apb(1, 12'hec, 8'he0);
    waitVec(6'h02);
    waitVec(6'h04);
    waitVec(6'h06);
    rd(12'he8, 32'h0);
    end_of_test;
  end
endmodule
